// >>> rtl/sdc_pkg.sv
// constants, types and helper functions of the six-decade counter and display scanner
package sdc_pkg;
  localparam int NDIG = 6;
  localparam int CNT_W = 24;
  // synchronised pin vector layout
  localparam int PIN_COUNT = 0;
  localparam int PIN_UP = 1;
  localparam int PIN_INH = 2;
  localparam int PIN_CLR = 3;
  localparam int PIN_STORE = 4;
  localparam int PIN_LDC = 5;
  localparam int PIN_LDR = 6;
  localparam int PIN_SCAN = 7;
  localparam int PIN_BCDC = 8;
  localparam int PIN_BCDR = 12;
  localparam int PIN_W = 16;
  // register map (byte addresses)
  localparam int AXI_AW = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_COUNT = 5'h04;
  localparam logic [4:0] REG_LATCH = 5'h08;
  localparam logic [4:0] REG_COMPARE = 5'h0c;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h10;
  localparam logic [4:0] REG_IRQ_CLEAR = 5'h14;
  localparam logic [4:0] REG_IRQ_ENABLE = 5'h18;
  localparam int CTRL_ZSD_BIT = 0;
  localparam int CTRL_VAR_LSB = 1;
  localparam int IRQ_W = 3;
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_WRAP = 1;
  localparam int IRQ_ZERO = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic READY_RST = 1'b1;
  localparam logic [2:0] SCAN_MSD = 3'h5;
  localparam logic [3:0] DIG_TOP_DEC = 4'h9;
  localparam logic [3:0] DIG_TOP_SIX = 4'h5;

  typedef enum logic [1:0] {SDC_DECIMAL, SDC_HMS, SDC_STOPWATCH} sdc_variant_t;

  // highest value of a decade; the time variants wrap two tens digits at six
  function automatic logic [3:0] sdc_digit_max(sdc_variant_t v, logic [2:0] i);
    logic [3:0] m;
    m = DIG_TOP_DEC;
    if (v == SDC_HMS && (i == 3'h1 || i == 3'h3))
      m = DIG_TOP_SIX;
    else if (v == SDC_STOPWATCH && (i == 3'h3 || i == 3'h5))
      m = DIG_TOP_SIX;
    return m;
  endfunction

  // seven-segment pattern, bit 0 = segment a through bit 6 = segment g
  function automatic logic [6:0] sdc_seg7(logic [3:0] d);
    logic [6:0] s;
    case (d)
      4'h0: s = 7'h3f;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5b;
      4'h3: s = 7'h4f;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6d;
      4'h6: s = 7'h7d;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7f;
      4'h9: s = 7'h6f;
      default: s = 7'h00;
    endcase
    return s;
  endfunction
endpackage

// >>> rtl/sdc_scan_if.sv
// signals between the counter core and the display scanner
`timescale 1ns/1ps
interface sdc_scan_if;
  logic [23:0] lat;
  logic zsd;
  logic scan_high;
  logic scan_fall;
  logic [2:0] idx;
  logic [5:0] strobe;
  logic [3:0] bcd;
  logic [6:0] seg;
  modport ctrl (output lat, zsd, scan_high, scan_fall, input idx, strobe, bcd, seg);
  modport scan (input lat, zsd, scan_high, scan_fall, output idx, strobe, bcd, seg);
endinterface

// >>> rtl/sdc_scanner.sv
// multiplexed display scanner with seven-segment decode and leading zero blanking
`timescale 1ns/1ps
module sdc_scanner (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // core side
  sdc_scan_if.scan sif
);
  import sdc_pkg::*;

  typedef struct packed {
    logic [2:0] idx;
    logic [5:0] strobe;
    logic [3:0] bcd;
    logic [6:0] seg;
  } sdc_scan_st_t;

  sdc_scan_st_t q;
  sdc_scan_st_t d;
  logic [3:0] dig;
  logic blank;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic nz;
    nz = 1'b0;
    d = q;
    if (sif.scan_fall)
      d.idx = (q.idx == 3'h0) ? SCAN_MSD : q.idx - 3'h1;
    dig = sif.lat[{d.idx, 2'b00} +: 4];
    for (int j = 0; j < NDIG; j++)
    begin
      if (j >= int'(d.idx) && sif.lat[j*4 +: 4] != 4'h0)
        nz = 1'b1;
    end
    blank = !sif.zsd && d.idx != 3'h0 && !nz;
    d.bcd = dig;
    d.strobe = sif.scan_high ? 6'(6'h1 << d.idx) : 6'h0;
    d.seg = (sif.scan_high && !blank) ? sdc_seg7(dig) : 7'h00;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.idx <= SCAN_MSD;
    end
    else
      q <= d;
  end

  assign sif.idx = q.idx;
  assign sif.strobe = q.strobe;
  assign sif.bcd = q.bcd;
  assign sif.seg = q.seg;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_one_strobe: assert property ($onehot0(q.strobe))
    else $error("more than one digit strobe active");
  a_scan_order: assert property (sif.scan_fall |=>
    q.idx == (($past(q.idx) == 3'h0) ? SCAN_MSD : $past(q.idx) - 3'h1))
    else $error("scan did not step toward the LSD");
  a_blank_gap: assert property (!sif.scan_high |=> q.strobe == 6'h0 && q.seg == 7'h00)
    else $error("strobe or segments on during interdigit gap");
  a_lz_blank: assert property (sif.scan_high && !sif.zsd && d.idx == SCAN_MSD
    && sif.lat[23:20] == 4'h0 |=> q.seg == 7'h00)
    else $error("leading zero in MSD not blanked");
  c_lz_blank: cover property (sif.scan_high && blank);
endmodule

// >>> rtl/sdc_counter.sv
// six-decade BCD up/down counter with compare register, latch and register bus
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module sdc_counter #(
  parameter sdc_pkg::sdc_variant_t VARIANT = sdc_pkg::SDC_DECIMAL
) (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // axi4-lite write address
  input logic [sdc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data and response
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // axi4-lite read
  input logic [sdc_pkg::AXI_AW-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // counter control pins
  input logic count_in,
  input logic up_down,
  input logic count_inhibit,
  input logic clear,
  input logic store,
  input logic load_counter,
  input logic load_register,
  input logic [3:0] bcd_counter_in,
  input logic [3:0] bcd_register_in,
  input logic scan_in,
  // display outputs
  output logic [5:0] digit_strobe,
  output logic [3:0] bcd_out,
  output logic [6:0] seg_out,
  // counter status outputs
  output logic match_out,
  output logic zero_out,
  output logic carry_out,
  output logic irq
);
  import sdc_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] prev;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cmp;
    logic [CNT_W-1:0] lat;
    logic match;
    logic zero;
    logic carry;
    logic ld_cnt_pend;
    logic ld_reg_pend;
    logic ld_inh;
    logic zsd;
    sdc_variant_t variant;
    logic [IRQ_W-1:0] sts;
    logic [IRQ_W-1:0] ien;
    logic irq;
    logic awready;
    logic [AXI_AW-1:0] awaddr;
    logic wready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sdc_state_t;

  sdc_state_t q;
  sdc_state_t d;
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] s;
  logic count_rise;
  logic count_fall;
  logic scan_rise;
  logic scan_fall;
  logic [3:0] bcdc;
  logic [3:0] bcdr;
  logic [NDIG:0] up_c;
  logic [NDIG:0] dn_c;
  logic [CNT_W-1:0] cnt_up;
  logic [CNT_W-1:0] cnt_dn;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] dig_mask;
  logic ld_wr_cnt;
  logic ld_wr_reg;
  logic ce;
  logic wrap;
  logic wr_fire;
  logic [IRQ_W-1:0] clr_bits;
  logic [IRQ_W-1:0] ev;

  sdc_scan_if sif ();

  sdc_scanner u_scan (
    .aclk(aclk),
    .aresetn(aresetn),
    .sif(sif)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pins pass two flip-flops; edges are taken from the second and a third stage
  assign pins_raw = {bcd_register_in, bcd_counter_in, scan_in, load_register,
    load_counter, store, clear, count_inhibit, up_down, count_in};
  assign s = q.s2;
  assign count_rise = s[PIN_COUNT] & ~q.prev[PIN_COUNT];
  assign count_fall = ~s[PIN_COUNT] & q.prev[PIN_COUNT];
  assign scan_rise = s[PIN_SCAN] & ~q.prev[PIN_SCAN];
  assign scan_fall = ~s[PIN_SCAN] & q.prev[PIN_SCAN];
  assign bcdc = s[PIN_BCDC +: 4];
  assign bcdr = s[PIN_BCDR +: 4];

  assign sif.lat = q.lat;
  assign sif.zsd = q.zsd;
  assign sif.scan_high = s[PIN_SCAN];
  assign sif.scan_fall = scan_fall;

  //////////////////////////////////////////////////////////////////////////////
  // next count for every decade at once from the look-ahead chains
  assign up_c[0] = 1'b1;
  assign dn_c[0] = 1'b1;
  for (genvar i = 0; i < NDIG; i++)
  begin : g_dig
    logic [3:0] dig;
    logic [3:0] dmax;
    assign dig = q.cnt[i*4 +: 4];
    assign dmax = sdc_digit_max(q.variant, 3'(i));
    assign up_c[i+1] = up_c[i] & (dig == dmax);
    assign dn_c[i+1] = dn_c[i] & (dig == 4'h0);
    assign cnt_up[i*4 +: 4] = !up_c[i] ? dig : ((dig == dmax) ? 4'h0 : 4'(dig + 4'h1));
    assign cnt_dn[i*4 +: 4] = !dn_c[i] ? dig : ((dig == 4'h0) ? dmax : 4'(dig - 4'h1));
  end

  assign cnt_next = s[PIN_UP] ? cnt_up : cnt_dn;
  assign wrap = s[PIN_UP] ? up_c[NDIG] : dn_c[NDIG];
  // a digit loads as its strobe ends, if the load was seen as the strobe began
  assign dig_mask = CNT_W'(24'hf) << {sif.idx, 2'b00};
  assign ld_wr_cnt = scan_fall & q.ld_cnt_pend;
  assign ld_wr_reg = scan_fall & q.ld_reg_pend;
  assign ce = count_rise & ~s[PIN_INH] & ~s[PIN_CLR] & ~ld_wr_cnt;
  assign wr_fire = !q.awready && !q.wready && !q.bvalid;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d = q;
    clr_bits = '0;
    d.s1 = pins_raw;
    d.s2 = q.s1;
    d.prev = q.s2;

    // load requests and the match/zero suppression that follows them
    if (scan_rise)
    begin
      d.ld_cnt_pend = s[PIN_LDC];
      d.ld_reg_pend = s[PIN_LDR];
    end
    else if (scan_fall)
    begin
      d.ld_cnt_pend = 1'b0;
      d.ld_reg_pend = 1'b0;
    end
    if (s[PIN_LDC] || s[PIN_LDR])
      d.ld_inh = 1'b1;
    else if (scan_fall)
      d.ld_inh = 1'b0;
    if (ld_wr_reg)
      d.cmp = (q.cmp & ~dig_mask) | ({NDIG{bcdr}} & dig_mask);

    // counter: clear overrides load, load overrides counting
    if (s[PIN_CLR])
      d.cnt = '0;
    else if (ld_wr_cnt)
      d.cnt = (q.cnt & ~dig_mask) | ({NDIG{bcdc}} & dig_mask);
    else if (ce)
      d.cnt = cnt_next;

    if (ce)
    begin
      d.match = (cnt_next == q.cmp) && !q.ld_inh;
      d.zero = (cnt_next == '0) && !q.ld_inh;
      d.carry = wrap;
    end
    else if (count_fall)
      d.carry = 1'b0;

    if (!s[PIN_STORE])
      d.lat = q.cnt;

    // register bus writes
    if (s_axi_awvalid && q.awready)
    begin
      d.awaddr = s_axi_awaddr;
      d.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
      d.wready = 1'b0;
    end
    if (wr_fire)
    begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (q.awaddr == REG_CTRL)
      begin
        if (q.wstrb[0])
        begin
          d.zsd = q.wdata[CTRL_ZSD_BIT];
          d.variant = sdc_variant_t'(q.wdata[CTRL_VAR_LSB +: 2]);
        end
      end
      else if (q.awaddr == REG_IRQ_ENABLE)
      begin
        if (q.wstrb[0])
          d.ien = q.wdata[IRQ_W-1:0];
      end
      else if (q.awaddr == REG_IRQ_CLEAR)
      begin
        if (q.wstrb[0])
          clr_bits = q.wdata[IRQ_W-1:0];
      end
      else if (q.awaddr != REG_COUNT && q.awaddr != REG_LATCH
        && q.awaddr != REG_COMPARE && q.awaddr != REG_IRQ_STATUS)
        d.bresp = RESP_SLVERR;
    end
    if (q.bvalid && s_axi_bready)
    begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // sticky events; a new event wins over a clear in the same cycle
    ev = '0;
    ev[IRQ_MATCH] = ce && d.match;
    ev[IRQ_WRAP] = ce && wrap;
    ev[IRQ_ZERO] = ce && d.zero;
    d.sts = (q.sts & ~clr_bits) | ev;
    d.irq = |(d.sts & d.ien);

    // register bus reads
    if (s_axi_arvalid && q.arready)
    begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h0;
      if (s_axi_araddr == REG_CTRL)
        d.rdata = {29'h0, q.variant, q.zsd};
      else if (s_axi_araddr == REG_COUNT)
        d.rdata = {8'h0, q.cnt};
      else if (s_axi_araddr == REG_LATCH)
        d.rdata = {8'h0, q.lat};
      else if (s_axi_araddr == REG_COMPARE)
        d.rdata = {8'h0, q.cmp};
      else if (s_axi_araddr == REG_IRQ_STATUS)
        d.rdata = {29'h0, q.sts};
      else if (s_axi_araddr == REG_IRQ_ENABLE)
        d.rdata = {29'h0, q.ien};
      else if (s_axi_araddr != REG_IRQ_CLEAR)
        d.rresp = RESP_SLVERR;
    end
    else if (q.rvalid && s_axi_rready)
    begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.variant <= VARIANT;
      q.awready <= READY_RST;
      q.wready <= READY_RST;
      q.arready <= READY_RST;
    end
    else
      q <= d;
  end

  //////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign digit_strobe = sif.strobe;
  assign bcd_out = sif.bcd;
  assign seg_out = sif.seg;
  assign match_out = q.match;
  assign zero_out = q.zero;
  assign carry_out = q.carry;
  assign irq = q.irq;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_count_up: assert property (ce && s[PIN_UP] && q.cnt[3:0] != 4'h9 |=>
    q.cnt[3:0] == $past(q.cnt[3:0]) + 4'h1)
    else $error("count did not step up");
  a_count_down: assert property (ce && !s[PIN_UP] && q.cnt[3:0] != 4'h0 |=>
    q.cnt[3:0] == $past(q.cnt[3:0]) - 4'h1)
    else $error("count did not step down");
  a_carry_all: assert property (ce && s[PIN_UP] && up_c[NDIG] |=>
    q.cnt == '0 && q.carry)
    else $error("full wrap missed or carry low");
  a_clear_zero: assert property (s[PIN_CLR] |=> q.cnt == '0)
    else $error("clear did not zero the counter");
  a_clear_keeps: assert property (s[PIN_CLR] && !ld_wr_reg |=> $stable(q.cmp))
    else $error("clear disturbed the compare register");
  a_inhibit_hold: assert property (s[PIN_INH] && !s[PIN_CLR] && !ld_wr_cnt
    |=> $stable(q.cnt))
    else $error("counter moved while inhibited");
  a_store_freeze: assert property (s[PIN_STORE] |=> $stable(q.lat))
    else $error("latch moved while stored");
  a_store_copy: assert property (!s[PIN_STORE] |=> q.lat == $past(q.cnt))
    else $error("latch did not follow counter");
  a_match_edge: assert property (ce && !ld_wr_reg |=>
    q.match == (q.cnt == q.cmp && !$past(q.ld_inh)))
    else $error("match wrong after count edge");
  a_match_hold: assert property (!ce |=> $stable(q.match))
    else $error("match changed between count edges");
  a_hms_wrap: assert property (ce && s[PIN_UP] && q.variant == SDC_HMS
    && q.cnt[7:0] == 8'h59 |=> q.cnt[7:0] == 8'h00)
    else $error("seconds field did not wrap at 60");
  a_sw_wrap: assert property (ce && s[PIN_UP] && q.variant == SDC_STOPWATCH
    && q.cnt[15:0] == 16'h5999 |=> q.cnt[15:0] == 16'h0000)
    else $error("stopwatch field did not wrap at 60");
  a_load_digit: assert property (ld_wr_cnt && !s[PIN_CLR] |=>
    ((q.cnt >> {$past(sif.idx), 2'b00}) & 24'hf) == {20'h0, $past(bcdc)})
    else $error("loaded digit differs from BCD input");
  a_irq_level: assert property (q.irq == |(q.sts & q.ien))
    else $error("interrupt level differs from enabled status");

  c_count_wrap: cover property (ce && wrap);
  c_match_seen: cover property (q.match);
  c_counter_load: cover property (ld_wr_cnt);
endmodule

// >>> dv/sdc_display_model.sv
// display, thumbwheel switch and scan oscillator model at the counter's pins
`timescale 1ns/1ps
module sdc_display_model (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // display side
  input logic [5:0] digit_strobe,
  // switch settings
  input logic [23:0] cnt_sw,
  input logic [23:0] reg_sw,
  // pins into the counter
  output logic scan_in = 1'b0,
  output logic [3:0] bcd_counter_in = 4'hf,
  output logic [3:0] bcd_register_in = 4'hf
);
  int ph = 0;
  // free-running scan oscillator: 12 cycles shown, 12 cycles gap
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ph <= 0;
      scan_in <= 1'b0;
      bcd_counter_in <= 4'hf;
      bcd_register_in <= 4'hf;
    end
    else
    begin
      ph <= (ph == 23) ? 0 : ph + 1;
      scan_in <= (ph < 12);
      // diodes feed the strobed decade; the line holds through the gap
      for (int i = 0; i < 6; i++)
        if (digit_strobe[i])
        begin
          bcd_counter_in <= cnt_sw[4*i+:4];
          bcd_register_in <= reg_sw[4*i+:4];
        end
    end
  end
endmodule

// >>> dv/testbench.sv
// self-checking bench of the six-decade counter and display scanner
`timescale 1ns/1ps
module testbench;
  import sdc_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [4:0] s_axi_awaddr = 0;
  logic [4:0] s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic count_in = 0, up_down = 1, count_inhibit = 0, clear = 0, store = 0;
  logic load_counter = 0, load_register = 0;
  logic scan_in;
  logic [3:0] bcd_counter_in, bcd_register_in, bcd_out;
  logic [5:0] digit_strobe;
  logic [6:0] seg_out;
  logic match_out, zero_out, carry_out, irq;
  logic [23:0] cnt_sw = 0, reg_sw = 0, r;
  logic [31:0] rs = 32'h2b57;
  logic [33:0] exq[$];
  logic [23:0] mx[3] = '{24'h999999, 24'h995959, 24'h595999};
  int err_total = 0, tests_run = 0, cyc = 0, n, carry_n = 0;
  logic carry_d = 0;

  always #5 aclk = ~aclk;

  sdc_counter sdc_counter_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .count_in, .up_down, .count_inhibit, .clear, .store,
    .load_counter, .load_register, .bcd_counter_in, .bcd_register_in, .scan_in,
    .digit_strobe, .bcd_out, .seg_out, .match_out, .zero_out, .carry_out, .irq);

  sdc_display_model sdc_display_model_i (.aclk, .aresetn, .digit_strobe, .cnt_sw, .reg_sw,
    .scan_in, .bcd_counter_in, .bcd_register_in);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic check(input logic [33:0] s, input logic [33:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    exq.push_back({e, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(s_axi_bvalid && s_axi_bready))
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [4:0] a, input logic [33:0] e);
    exq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!(s_axi_rvalid && s_axi_rready))
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  // direction settles before the first rising count edge
  task automatic pulse(input logic up, input int k);
    @(posedge aclk);
    up_down <= up;
    repeat (3) @(posedge aclk);
    repeat (k)
    begin
      count_in <= 1'b1;
      repeat (6) @(posedge aclk);
      count_in <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask

  task automatic clr;
    @(posedge aclk);
    clear <= 1'b1;
    repeat (6) @(posedge aclk);
    clear <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic wait_dig(input int d);
    int w;
    w = 0;
    while (digit_strobe !== (6'h1 << d) && w < 500)
    begin
      @(posedge aclk);
      w++;
    end
    @(posedge aclk);
  endtask

  task automatic ld(input bit cnt);
    @(posedge aclk);
    if (cnt)
      load_counter <= 1'b1;
    else
      load_register <= 1'b1;
    repeat (170) @(posedge aclk);
    load_counter <= 1'b0;
    load_register <= 1'b0;
    repeat (60) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // response watcher: every answer takes the oldest expectation
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      check({s_axi_rresp, s_axi_rdata}, exq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      check({s_axi_bresp, 32'h0}, exq.pop_front());
    // every wrapping count edge gives one carry pulse
    carry_d <= carry_out;
    if (carry_out && !carry_d)
      carry_n++;
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      test_done;
    end
  end

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    for (int a = 0; a < 32; a += 4)
      axr(5'(a), (a == 28) ? {RESP_SLVERR, 32'h0} : 34'h0);
    axw(5'h1c, 32'h1, RESP_SLVERR);
    axw(REG_COUNT, 32'h77, RESP_OKAY);
    rs = xs(rs);
    n = 3 + int'(rs % 5);
    pulse(1'b1, n);
    axr(REG_COUNT, 34'(n));
    count_inhibit <= 1'b1;
    pulse(1'b1, 3);
    count_inhibit <= 1'b0;
    axr(REG_COUNT, 34'(n));
    store <= 1'b1;
    pulse(1'b1, 2);
    axr(REG_COUNT, 34'(n + 2));
    axr(REG_LATCH, 34'(n));
    store <= 1'b0;
    repeat (3) @(posedge aclk);
    axr(REG_LATCH, 34'(n + 2));
    store <= 1'b1;
    clr;
    axr(REG_COUNT, 34'h0);
    axr(REG_LATCH, 34'(n + 2));
    store <= 1'b0;
    pulse(1'b1, 1);
    pulse(1'b0, 1);
    check(34'(zero_out), 34'h1);
    axw(REG_IRQ_CLEAR, 32'h7, RESP_OKAY);
    // borrow and carry through all decades in every variant
    for (int v = 0; v < 3; v++)
    begin
      axw(REG_CTRL, 32'(v << 1), RESP_OKAY);
      clr;
      pulse(1'b0, 1);
      axr(REG_COUNT, 34'(mx[v]));
      pulse(1'b1, 1);
      axr(REG_COUNT, 34'h0);
    end
    axr(REG_IRQ_STATUS, 34'h7);
    check(34'(irq), 34'h0);
    axw(REG_IRQ_ENABLE, 32'h2, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(34'(irq), 34'h1);
    axw(REG_IRQ_CLEAR, 32'h7, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(34'(irq), 34'h0);
    // display of 000012 with and without zero suppression
    axw(REG_CTRL, 32'h0, RESP_OKAY);
    clr;
    pulse(1'b1, 12);
    wait_dig(5);
    check(34'({seg_out, bcd_out}), 34'h0);
    wait_dig(2);
    check(34'({seg_out, bcd_out}), 34'h0);
    wait_dig(1);
    check(34'({seg_out, bcd_out}), 34'h061);
    wait_dig(0);
    check(34'({seg_out, bcd_out}), 34'h5b2);
    axw(REG_CTRL, 32'h1, RESP_OKAY);
    wait_dig(5);
    check(34'({seg_out, bcd_out}), 34'h3f0);
    for (int i = 4; i >= -1; i--)
    begin
      while (digit_strobe === 6'h0 || digit_strobe === ((i < 0) ? 6'h01 : 6'h1 << (i + 1)))
        @(posedge aclk);
      @(posedge aclk);
      check(34'(digit_strobe), (i < 0) ? 34'h20 : 34'h1 << i);
    end
    // digit-by-digit loads of register, then counter
    for (int i = 0; i < 6; i++)
    begin
      rs = xs(rs);
      r[4*i+:4] = 4'(rs % 10);
    end
    @(posedge aclk);
    cnt_sw <= r;
    reg_sw <= r;
    ld(1'b0);
    axr(REG_COMPARE, 34'(r));
    axr(REG_COUNT, 34'h12);
    ld(1'b1);
    axr(REG_COUNT, 34'(r));
    axw(REG_IRQ_ENABLE, 32'h1, RESP_OKAY);
    pulse(1'b0, 1);
    check(34'(match_out), 34'h0);
    pulse(1'b1, 1);
    check(34'(match_out), 34'h1);
    check(34'(irq), 34'h1);
    // six variant wraps, plus two more when the loaded value was zero
    check(34'(carry_n), (r == 24'h0) ? 34'h8 : 34'h6);
    test_done;
  end
endmodule
